/* File: design/subtract_swap_skip_pkg.sv */
// Package with register map, command layout, opcodes and reset values of the execution slice.
package subtract_swap_skip_pkg;

    // Byte addresses of the register words on the bus.
    localparam logic [31:0] CMD_OFFSET    = 32'h0000_0000;
    localparam logic [31:0] ACC_OFFSET    = 32'h0000_0004;
    localparam logic [31:0] FLAGS_OFFSET  = 32'h0000_0008;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_000C;
    localparam logic [31:0] PC_OFFSET     = 32'h0000_0010;
    localparam logic [31:0] MEM_BASE      = 32'h0000_0100;

    // Largest data memory that fits below the end of the map.
    localparam int MEM_DEPTH_MAX = 64;

    // Opcodes written into the command register.
    localparam logic [3:0] OP_SUBTRACT_TO_MEMORY     = 4'h1;
    localparam logic [3:0] OP_SUBTRACT_IMMEDIATE     = 4'h2;
    localparam logic [3:0] OP_NIBBLE_EXCHANGE_MEM    = 4'h3;
    localparam logic [3:0] OP_NIBBLE_EXCHANGE_TO_ACC = 4'h4;
    localparam logic [3:0] OP_SKIP_IF_ZERO           = 4'h5;
    localparam logic [3:0] OP_SKIP_ZERO_LOAD_ACC     = 4'h6;
    localparam logic [3:0] OP_SKIP_IF_BIT_CLEAR      = 4'h7;

    // Status word field positions.
    localparam int STATUS_BUSY_BIT   = 0;
    localparam int STATUS_SKIP_BIT   = 1;
    localparam int STATUS_CYCLES_LSB = 8;

    // Values after reset.
    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic [3:0]  FLAGS_RESET  = 4'h0;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
    localparam logic [1:0]  CYCLES_RESET = 2'h0;

    // Program counter steps for a normal and a skipped successor.
    localparam logic [15:0] PC_STEP      = 16'h0001;
    localparam logic [15:0] PC_SKIP_STEP = 16'h0002;

    // Cycle counts reported for one- and two-cycle instructions.
    localparam logic [1:0] CYCLES_SINGLE = 2'h1;
    localparam logic [1:0] CYCLES_SKIP   = 2'h2;

    // Command word: opcode in bits 3..0, memory index 13..8, bit 18..16, immediate 31..24.
    typedef struct packed {
        logic [7:0] imm;
        logic [4:0] rsvdHigh;
        logic [2:0] bitSel;
        logic [1:0] rsvdMid;
        logic [5:0] memAddr;
        logic [3:0] rsvdLow;
        logic [3:0] op;
    } cmd_t;

    // Flag word: borrow-inverse in bit 0, half borrow 1, zero 2, signed wrap 3.
    typedef struct packed {
        logic signedWrapFlag;
        logic zeroFlag;
        logic halfBorrowFlag;
        logic borrowInvFlag;
    } flags_t;

    typedef enum logic [1:0] {
        EX_IDLE,
        EX_RUN,
        EX_DUMMY
    } exec_state_t;

endpackage

/* File: design/subtract_swap_skip_ops.sv */
// Execution slice for subtract, nibble exchange and skip instructions behind an AHB-Lite slave.
//
// Functional notes
// [RL1] The subtract-to-memory command writes accumulator minus the memory byte into that byte and updates all four arithmetic flags.
// [RL2] Every subtraction clears the borrow-inverse flag when the difference is negative and sets it when it is positive or zero.
// [RL3] The immediate subtract command takes the immediate from the command, leaves the difference in the accumulator and updates the same four flags.
// [RL4] The in-place nibble exchange swaps the two halves of the memory byte and leaves the flags alone.
// [RL5] The nibble exchange to accumulator puts the byte's high half into the accumulator's low half and its low half into the high half, touching neither memory nor flags.
// [RL6] The skip-if-zero command skips the next instruction when the memory byte is zero and changes no flag.
// [RL7] The skip-zero-load command copies the memory byte into the accumulator and skips when it is zero, changing no flag.
// [RL8] The skip-if-bit-clear command skips when the selected bit of the memory byte is zero and changes no flag.
// [RL9] Every skip command takes two instruction cycles, the second being a dummy cycle.
// [RL10] When a skip condition fails, execution continues at the instruction right after the skip.
// [RL11] Zero comes from an all-zero result, half borrow from the low-nibble borrow, signed wrap from two's-complement overflow.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module subtract_swap_skip_ops #(
    parameter int MEM_DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             skipTaken,
    output logic             busy
);

    localparam int AW = $clog2(MEM_DEPTH);
    localparam logic [31:0] MEM_END = subtract_swap_skip_pkg::MEM_BASE + 32'(4 * MEM_DEPTH);

    if (MEM_DEPTH < 2 || MEM_DEPTH > subtract_swap_skip_pkg::MEM_DEPTH_MAX
        || (1 << AW) != MEM_DEPTH)
    begin : g_bad_depth
        $error("MEM_DEPTH must be a power of two from 2 to 64.");
    end

    // The memory index is cut straight from the low address bits, which needs this alignment.
    if ((subtract_swap_skip_pkg::MEM_BASE & 32'(4 * MEM_DEPTH - 1)) != 32'h0000_0000)
    begin : g_bad_base
        $error("The memory window must start on a multiple of its own size.");
    end

    // Bus address and data phase tracking.
    logic        dpWrite;
    logic        dpRead;
    logic [31:0] dpAddr;

    // Architectural state.
    subtract_swap_skip_pkg::cmd_t        cmd;
    subtract_swap_skip_pkg::flags_t      flags;
    subtract_swap_skip_pkg::exec_state_t state;
    logic [7:0]  acc;
    logic [15:0] pc;
    logic        lastSkip;
    logic [1:0]  lastCycles;
    logic [7:0]  mem [MEM_DEPTH];

    wire addrPhase = hsel & hready & htrans[1];
    wire idle      = (state == subtract_swap_skip_pkg::EX_IDLE);

    // Register decode in the data phase.
    wire selCmd    = (dpAddr == subtract_swap_skip_pkg::CMD_OFFSET);
    wire selAcc    = (dpAddr == subtract_swap_skip_pkg::ACC_OFFSET);
    wire selFlags  = (dpAddr == subtract_swap_skip_pkg::FLAGS_OFFSET);
    wire selStatus = (dpAddr == subtract_swap_skip_pkg::STATUS_OFFSET);
    wire selPc     = (dpAddr == subtract_swap_skip_pkg::PC_OFFSET);
    wire selMem    = (dpAddr >= subtract_swap_skip_pkg::MEM_BASE) && (dpAddr < MEM_END)
                     && (dpAddr[1:0] == 2'b00);
    wire [AW-1:0] busIdx = dpAddr[AW+1:2];

    // State-changing bus writes are ignored while a command runs, so the core owns its state.
    wire busWr     = dpWrite & idle;
    wire wrCmd     = busWr & selCmd;
    wire wrAcc     = busWr & selAcc;
    wire wrFlags   = busWr & selFlags;
    wire wrPc      = busWr & selPc;
    wire wrMem     = busWr & selMem;

    // Operand fetch and arithmetic for the running command.
    wire [AW-1:0] cmdIdx  = cmd.memAddr[AW-1:0];
    wire [7:0]    operand = mem[cmdIdx];
    wire isSubMem  = (cmd.op == subtract_swap_skip_pkg::OP_SUBTRACT_TO_MEMORY);
    wire isSubImm  = (cmd.op == subtract_swap_skip_pkg::OP_SUBTRACT_IMMEDIATE);
    wire isSwapMem = (cmd.op == subtract_swap_skip_pkg::OP_NIBBLE_EXCHANGE_MEM);
    wire isSwapAcc = (cmd.op == subtract_swap_skip_pkg::OP_NIBBLE_EXCHANGE_TO_ACC);
    wire isSkipZ   = (cmd.op == subtract_swap_skip_pkg::OP_SKIP_IF_ZERO);
    wire isSkipLd  = (cmd.op == subtract_swap_skip_pkg::OP_SKIP_ZERO_LOAD_ACC);
    wire isSkipBit = (cmd.op == subtract_swap_skip_pkg::OP_SKIP_IF_BIT_CLEAR);
    wire isSkip    = isSkipZ | isSkipLd | isSkipBit;
    wire isSub     = isSubMem | isSubImm;

    wire [7:0] subtrahend = isSubImm ? cmd.imm : operand;
    wire [8:0] diff       = {1'b0, acc} - {1'b0, subtrahend};
    wire [4:0] lowDiff    = {1'b0, acc[3:0]} - {1'b0, subtrahend[3:0]};
    wire [7:0] result     = diff[7:0];
    wire [7:0] swapped    = {operand[3:0], operand[7:4]};

    subtract_swap_skip_pkg::flags_t subFlags;
    assign subFlags.borrowInvFlag  = ~diff[8];                                           // RL2
    assign subFlags.halfBorrowFlag = lowDiff[4];                                         // RL11
    assign subFlags.zeroFlag       = (result == 8'h00);                                  // RL11
    assign subFlags.signedWrapFlag = (acc[7] != subtrahend[7]) && (result[7] != acc[7]); // RL11

    wire operandZero = (operand == 8'h00);
    wire bitClear    = ~operand[cmd.bitSel];
    wire skipCond    = ((isSkipZ | isSkipLd) & operandZero) | (isSkipBit & bitClear); // RL6 RL8

    wire running     = (state == subtract_swap_skip_pkg::EX_RUN);
    wire execMemWr   = running & (isSubMem | isSwapMem);
    wire [7:0] execMemData = isSubMem ? result : swapped; // RL1 RL4

    wire          memWe    = execMemWr | wrMem;
    wire [AW-1:0] memWaddr = execMemWr ? cmdIdx : busIdx;
    wire [7:0]    memWdata = execMemWr ? execMemData : hwdata[7:0];

    // Read selection for the bus.
    wire [31:0] statusWord = (32'(lastCycles) << subtract_swap_skip_pkg::STATUS_CYCLES_LSB)
                           | (32'(lastSkip) << subtract_swap_skip_pkg::STATUS_SKIP_BIT)
                           | (32'(busy) << subtract_swap_skip_pkg::STATUS_BUSY_BIT);
    logic [31:0] readMux;
    always_comb
    begin
        if (selCmd)
        begin
            readMux = cmd;
        end
        else if (selAcc)
        begin
            readMux = {24'h00_0000, acc};
        end
        else if (selFlags)
        begin
            readMux = {28'h000_0000, flags};
        end
        else if (selStatus)
        begin
            readMux = statusWord;
        end
        else if (selPc)
        begin
            readMux = {16'h0000, pc};
        end
        else if (selMem)
        begin
            readMux = {24'h00_0000, mem[busIdx]};
        end
        else
        begin
            readMux = 32'h0000_0000;
        end
    end

    // Reads take one wait state so hrdata comes from a flop and sees any write just before.
    assign hreadyout = ~dpRead;
    assign hresp     = 1'b0;
    assign busy      = ~idle;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dpWrite <= 1'b0;
            dpRead  <= 1'b0;
        end
        else if (hready)
        begin
            dpWrite <= addrPhase & hwrite;
            dpRead  <= addrPhase & ~hwrite;
        end
        else
        begin
            dpWrite <= 1'b0;
            dpRead  <= 1'b0;
        end
    end

    // The address is kept only from accepted address phases, so idle cycles cannot move it.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dpAddr <= 32'h0000_0000;
        end
        else if (addrPhase)
        begin
            dpAddr <= haddr;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (dpRead)
        begin
            hrdata <= readMux;
        end
    end

    // Data memory, one byte of flip-flops per entry.
    for (genvar i = 0; i < MEM_DEPTH; i++)
    begin : g_mem
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                mem[i] <= 8'h00;
            end
            else if (memWe && memWaddr == AW'(i))
            begin
                mem[i] <= memWdata;
            end
        end
    end

    // Sequencer: a command runs one cycle, and a skip command adds a dummy cycle.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= subtract_swap_skip_pkg::EX_IDLE;
        end
        else
        begin
            case (state)
                subtract_swap_skip_pkg::EX_IDLE:
                begin
                    if (wrCmd)
                    begin
                        state <= subtract_swap_skip_pkg::EX_RUN;
                    end
                end
                subtract_swap_skip_pkg::EX_RUN:
                begin
                    state <= isSkip ? subtract_swap_skip_pkg::EX_DUMMY   // RL9
                                    : subtract_swap_skip_pkg::EX_IDLE;
                end
                subtract_swap_skip_pkg::EX_DUMMY:
                begin
                    state <= subtract_swap_skip_pkg::EX_IDLE; // RL9
                end
                default:
                begin
                    state <= subtract_swap_skip_pkg::EX_IDLE;
                end
            endcase
        end
    end

    // The command word is latched once, so its operand fields stay put through the dummy cycle.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd <= subtract_swap_skip_pkg::CMD_RESET;
        end
        else if (wrCmd)
        begin
            cmd <= hwdata;
        end
    end

    // Next values; bus writes reach them only while idle, so a running command always wins.
    wire [15:0] pcStep  = (isSkip && skipCond) ? subtract_swap_skip_pkg::PC_SKIP_STEP
                                               : subtract_swap_skip_pkg::PC_STEP; // RL10
    wire [7:0]  next_acc =
        (running && isSubImm)  ? result :  // RL3
        (running && isSwapAcc) ? swapped : // RL5
        (running && isSkipLd)  ? operand : // RL7
        wrAcc                  ? hwdata[7:0] :
                                 acc;
    wire [15:0] next_pc =
        running ? pc + pcStep : // RL10
        wrPc    ? hwdata[15:0] :
                  pc;
    wire [1:0]  cmdCycles = isSkip ? subtract_swap_skip_pkg::CYCLES_SKIP // RL9
                                   : subtract_swap_skip_pkg::CYCLES_SINGLE;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            acc <= subtract_swap_skip_pkg::ACC_RESET;
        end
        else
        begin
            acc <= next_acc;
        end
    end

    // Only subtractions touch the flags; exchanges and skips leave them as they were.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags <= subtract_swap_skip_pkg::FLAGS_RESET;
        end
        else if (running && isSub)
        begin
            flags <= subFlags; // RL1 RL3
        end
        else if (wrFlags)
        begin
            flags <= hwdata[3:0];
        end
    end

    // The program counter stands in for the fetch path: one step normally, two on a skip.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pc <= subtract_swap_skip_pkg::PC_RESET;
        end
        else
        begin
            pc <= next_pc;
        end
    end

    // Skip report and cycle count of the last command, kept for software to read back.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lastSkip   <= 1'b0;
            lastCycles <= subtract_swap_skip_pkg::CYCLES_RESET;
        end
        else if (running)
        begin
            lastSkip   <= isSkip & skipCond;
            lastCycles <= cmdCycles; // RL9
        end
    end

    // Registered so that the pulse falls in the dummy cycle rather than the execute cycle.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            skipTaken <= 1'b0;
        end
        else
        begin
            skipTaken <= running & isSkip & skipCond; // RL6 RL7 RL8
        end
    end

endmodule

/* File: testbench/subtract_swap_skip_chk.sv */
// Concurrent checks on the ports of the subtract, exchange and skip slice.
`timescale 1ns/1ps

module subtract_swap_skip_chk #(
    parameter int MEM_DEPTH = 16
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        skipTaken,
    input wire logic        busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    wire addrTaken = hsel && hready && htrans[1];
    wire cmdWrite  = addrTaken && hwrite && (haddr == subtract_swap_skip_pkg::CMD_OFFSET);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp is not OKAY");
    a_read_wait: assert property (addrTaken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (addrTaken && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_cmd_start: assert property (cmdWrite ##1 !busy |=> busy)
        else $error("command did not start");
    a_busy_max: assert property (busy ##1 busy |=> !busy)
        else $error("command longer than two cycles");
    a_skip_window: assert property (skipTaken |-> busy && $past(busy) && !$past(busy, 2))
        else $error("skip pulse outside dummy cycle");
    a_skip_pulse: assert property (skipTaken |=> !skipTaken)
        else $error("skip pulse too long");
    a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");

    c_skip: cover property (skipTaken);
    c_two_cycle: cover property (busy ##1 busy ##1 !busy);
    c_cmd: cover property (cmdWrite);
endmodule

bind subtract_swap_skip_ops subtract_swap_skip_chk #(.MEM_DEPTH(MEM_DEPTH)) chk_i (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .skipTaken(skipTaken),
    .busy(busy)
);

/* File: testbench/subtract_swap_skip_ops_bench.sv */
// Self-checking bench that runs every opcode with random and corner operands.
`timescale 1ns/1ps

module subtract_swap_skip_ops_bench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire         hready;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         skipTaken;
    wire         busy;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [7:0]  rnd = 8'h2e;

    assign hready = hreadyout;
    always #20 clk = ~clk;

    subtract_swap_skip_ops #(.MEM_DEPTH(16)) subtract_swap_skip_ops_i (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .skipTaken(skipTaken),
        .busy(busy)
    );

    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end

    function automatic logic [7:0] nextRnd(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Returns signed wrap, zero, half borrow, borrow-inverse and the 8-bit difference.
    function automatic logic [11:0] subRef(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        return {(a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] < b[3:0], a >= b, r};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single transfer; hready is sampled at the settled level seen just before each edge.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic r;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        r = 1'b0;
        while (r !== 1'b1)
        begin
            @(negedge clk);
            r = hreadyout;
            @(posedge clk);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        r = 1'b0;
        while (r !== 1'b1)
        begin
            @(negedge clk);
            r = hreadyout;
            q = hrdata;
            @(posedge clk);
        end
    endtask

    task automatic rdCheck(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(what, exp, q);
    endtask

    task automatic runOp(input logic [3:0] op, input logic [7:0] acc, input logic [7:0] m,
                         input logic [2:0] bitSel, input logic [3:0] idx);
        logic [31:0] q;
        logic [31:0] memAddr;
        logic [11:0] s;
        logic [7:0]  eAcc;
        logic [7:0]  eMem;
        logic [3:0]  eFlg;
        logic        skip;
        logic [1:0]  cyc;
        logic [3:0]  nBusy;
        logic [3:0]  nSkip;
        memAddr = subtract_swap_skip_pkg::MEM_BASE + {26'h0, idx, 2'b00};
        eFlg = rnd[3:0];
        bus(1'b1, subtract_swap_skip_pkg::ACC_OFFSET, {24'h0, acc}, q);
        bus(1'b1, subtract_swap_skip_pkg::FLAGS_OFFSET, {28'h0, eFlg}, q);
        bus(1'b1, subtract_swap_skip_pkg::PC_OFFSET, 32'h0000_0100, q);
        bus(1'b1, memAddr, {24'h0, m}, q);
        s = subRef(acc, (op == 4'h2) ? rnd : m);
        eAcc = acc;
        eMem = m;
        skip = 1'b0;
        cyc = (op >= 4'h5 && op <= 4'h7) ? 2'h2 : 2'h1;
        case (op)
            4'h1: begin eMem = s[7:0]; eFlg = s[11:8]; end
            4'h2: begin eAcc = s[7:0]; eFlg = s[11:8]; end
            4'h3: eMem = {m[3:0], m[7:4]};
            4'h4: eAcc = {m[3:0], m[7:4]};
            4'h5: skip = (m == 8'h00);
            4'h6: begin eAcc = m; skip = (m == 8'h00); end
            4'h7: skip = !m[bitSel];
            default: ;
        endcase
        bus(1'b1, subtract_swap_skip_pkg::CMD_OFFSET,
            {rnd, 5'h0, bitSel, 4'h0, idx, 4'h0, op}, q);
        nBusy = 4'h0;
        nSkip = 4'h0;
        repeat (4)
        begin
            @(negedge clk);
            nBusy = nBusy + {3'h0, busy};
            nSkip = nSkip + {3'h0, skipTaken};
        end
        check("busy cycles", {30'h0, cyc}, {28'h0, nBusy});
        check("skip pulses", {31'h0, skip}, {28'h0, nSkip});
        @(posedge clk);
        rdCheck("acc", subtract_swap_skip_pkg::ACC_OFFSET, {24'h0, eAcc});
        rdCheck("flags", subtract_swap_skip_pkg::FLAGS_OFFSET, {28'h0, eFlg});
        rdCheck("mem", memAddr, {24'h0, eMem});
        rdCheck("pc", subtract_swap_skip_pkg::PC_OFFSET, skip ? 32'h0000_0102 : 32'h0000_0101);
        rdCheck("status", subtract_swap_skip_pkg::STATUS_OFFSET, {22'h0, cyc, 6'h0, skip, 1'b0});
    endtask

    initial
    begin
        logic [7:0]  a;
        logic [7:0]  m;
        logic [31:0] q;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rdCheck("acc reset", subtract_swap_skip_pkg::ACC_OFFSET, 32'h0000_0000);
        rdCheck("flags reset", subtract_swap_skip_pkg::FLAGS_OFFSET, 32'h0000_0000);
        rdCheck("pc reset", subtract_swap_skip_pkg::PC_OFFSET, 32'h0000_0000);
        // Unmapped places and the read-only status word must not take writes.
        bus(1'b1, subtract_swap_skip_pkg::STATUS_OFFSET, 32'hffff_ffff, q);
        rdCheck("status ro", subtract_swap_skip_pkg::STATUS_OFFSET, 32'h0000_0000);
        bus(1'b1, 32'h0000_0020, 32'h1234_5678, q);
        rdCheck("unmapped", 32'h0000_0020, 32'h0000_0000);
        for (int op = 0; op < 9; op++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                rnd = nextRnd(rnd);
                a = (k == 2) ? 8'h80 : rnd;
                rnd = nextRnd(rnd);
                m = (k == 0) ? 8'h00 : (k == 1) ? a : (k == 2) ? 8'h01 : rnd;
                runOp(op[3:0], a, m, k[2:0], rnd[3:0]);
            end
        end
        // A register write whose data phase falls in the dummy cycle of a skip is dropped.
        bus(1'b1, subtract_swap_skip_pkg::CMD_OFFSET,
            {28'h000_0000, subtract_swap_skip_pkg::OP_SKIP_IF_ZERO}, q);
        bus(1'b1, subtract_swap_skip_pkg::ACC_OFFSET, {24'h0, ~a}, q);
        rdCheck("acc write while busy", subtract_swap_skip_pkg::ACC_OFFSET, {24'h0, a});
        stop_test();
    end
endmodule
